//--- logic/asp_pkg.sv
// Purpose: shared constants for the angle sample preprocessing chain
// Assumes: 16-bit internal angle words, 200 MHz clock
// Notes:   register offsets, sample and angle word widths and power-on timing counts live here
package asp_pkg;
    localparam int               ANGLE_W       = 16;
    localparam int               SAMPLE_W      = 16;
    localparam int               RATE_W        = 3;
    localparam int               ACC_W         = 24;
    localparam int               DECIM_LOG     = 2;
    localparam int               TAPS          = 4;
    localparam int               COEF_W        = 16;
    localparam int               TEMP_W        = 12;
    localparam int               CLK_MHZ       = 200;
    localparam int               BASE_PERIOD_US = 32;
    localparam int               BASE_PERIOD_CYC = BASE_PERIOD_US * CLK_MHZ;
    localparam int               POR_BIST_US   = 100;
    localparam int               POR_BIST_CYC  = POR_BIST_US * CLK_MHZ;
    localparam int               POR_SIG_MS    = 36;
    localparam int               POR_SIG_CYC   = POR_SIG_MS * 1000 * CLK_MHZ;
    localparam logic [3:0]       REG_IIR_C0    = 4'h0;
    localparam logic [3:0]       REG_IIR_C1    = 4'h1;
    localparam logic [3:0]       REG_IIR_C2    = 4'h2;
    localparam logic [3:0]       REG_CTRL      = 4'h3;
    localparam logic [3:0]       REG_TEMP      = 4'h4;
    localparam logic [3:0]       REG_STATUS    = 4'h5;
    localparam logic [3:0]       REG_ANGLE     = 4'h6;
    localparam int               CTRL_RATE_LSB = 0;
    localparam int               CTRL_IIR_BIT  = 3;
    localparam int               CTRL_ROT_BIT  = 4;
    localparam int               CTRL_TC_BIT   = 5;
    localparam int               CTRL_STA_BIT  = 6;
    localparam int               CTRL_STB_BIT  = 7;
    localparam logic [15:0]      CTRL_RESET    = 16'h0000;
    localparam logic [15:0]      COEF_RESET    = 16'h0000;
    localparam logic [15:0]      TC_SLOPE      = 16'h0010;
    localparam logic [11:0]      TC_REF_TEMP   = 12'h800;
    localparam logic [15:0]      ST_BIT_POR    = 16'h0001;
endpackage

//--- logic/asp_fir.sv
// Purpose: decimating band-pass conditioner for raw front-end samples
// Assumes: in_valid one cycle per sample
// Notes:   difference of two box sums gives a crude band-pass
`timescale 1ns/1ps
module asp_fir
(
    // clock
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // samples in
    input  wire logic                        in_valid,
    input  wire logic [asp_pkg::SAMPLE_W-1:0] in_data,
    // conditioned out
    output logic                             out_valid,
    output logic [asp_pkg::SAMPLE_W-1:0]     out_data
);
    import asp_pkg::*;
    typedef struct packed {
        logic [DECIM_LOG-1:0]    phase;
        logic [SAMPLE_W+1:0]     sum;
        logic [SAMPLE_W-1:0]     prev;
        logic                    ov;
        logic [SAMPLE_W-1:0]     od;
    } asp_fir_t;
    asp_fir_t s, next_s;
    logic [SAMPLE_W+1:0] acc;

    always_comb
    begin
        next_s = s;
        next_s.ov = 1'b0;
        acc = s.sum + {2'h0, in_data};
        if (in_valid)
        begin
            next_s.phase = s.phase + 1'b1;
            next_s.sum = acc;
            if (s.phase == '1)
            begin
                // high-pass by first difference of the decimated average
                next_s.ov = 1'b1;
                next_s.od = acc[SAMPLE_W+1:2] - s.prev + 16'h8000;
                next_s.prev = acc[SAMPLE_W+1:2];
                next_s.sum = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else if (ce)
            s <= next_s;
    end
    assign out_valid = s.ov;
    assign out_data = s.od;

    decim_rate_a : assert property (@(posedge clk) disable iff (!rst_n)
        ce && in_valid && s.phase == '1 |=> out_valid) else $error("no decimated output");
endmodule

//--- logic/asp_buf2.sv
// Purpose: two-entry skid buffer with valid/ready both sides
// Assumes: single clock
// Notes:   full throughput, no combinational ready path from out side
`timescale 1ns/1ps
module asp_buf2
(
    // clock
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // fill side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [asp_pkg::ANGLE_W-1:0] in_data,
    // drain side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [asp_pkg::ANGLE_W-1:0]     out_data
);
    import asp_pkg::*;
    typedef struct packed {
        logic [1:0]              cnt;
        logic [ANGLE_W-1:0]      d0;
        logic [ANGLE_W-1:0]      d1;
    } asp_buf_t;
    asp_buf_t s, next_s;
    logic push, pop;

    always_comb
    begin
        next_s = s;
        push = in_valid && (s.cnt != 2'h2) && ce;
        pop = out_ready && (s.cnt != 2'h0) && ce;
        if (pop)
        begin
            next_s.d0 = s.d1;
        end
        if (push)
        begin
            if ((s.cnt == 2'h0) || (s.cnt == 2'h1 && pop))
                next_s.d0 = in_data;
            else
                next_s.d1 = in_data;
        end
        next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else if (ce)
            s <= next_s;
    end
    assign in_ready = (s.cnt != 2'h2);
    assign out_valid = (s.cnt != 2'h0);
    assign out_data = s.d0;

    buf_bound_a : assert property (@(posedge clk) disable iff (!rst_n)
        s.cnt <= 2'h2) else $error("buffer count overflow");
endmodule

//--- logic/asp_chain.sv
// Purpose: front end conditioning, raw angle, averaging, IIR, temp comp, rotation
// Assumes: ADC samples synchronous to CLK; register port one word per address
// Notes:   raw angle is the conditioned sample word itself (phase-coded front end)
`timescale 1ns/1ps
// Behaviour
// - average 2^n samples, n the 3-bit rate field, period 32 us times 2^n
// - accumulate raw angles and emit one averaged result per refresh period
// - decimate and band-pass filter samples before angle computation
// - one raw angle per conditioned sample
// - IIR applied only when its enable bit is set, else bypassed
// - IIR coefficients come from writable storage
// - correct linear temperature drift with factory coefficients
// - rotation bit picks increasing direction, applied after temperature compensation
// - each optional stage individually enabled; disabled stages are skipped
// - power-on runs POR_SIG only when selected by configuration; POR_BIST always ends after one cycle, as ctrl resets to zero
module asp_chain
#(
    parameter int BIST_CYC = asp_pkg::POR_BIST_CYC,
    parameter int SIG_CYC  = asp_pkg::POR_SIG_CYC
)
(
    // clock and reset
    input  wire logic                         CLK,
    input  wire logic                         RST_N,
    input  wire logic                         CE,
    // adc stream
    input  wire logic                         ADC_VALID,
    input  wire logic [asp_pkg::SAMPLE_W-1:0] ADC_DATA,
    input  wire logic [asp_pkg::TEMP_W-1:0]   TEMP_CODE,
    // register port
    input  wire logic [3:0]                   REG_ADDR,
    input  wire logic [15:0]                  REG_WDATA,
    input  wire logic                         REG_WR,
    input  wire logic                         REG_RD,
    output logic [15:0]                       REG_RDATA,
    // downstream
    output logic                              ANGLE_VALID,
    input  wire logic                         ANGLE_READY,
    output logic [asp_pkg::ANGLE_W-1:0]       ANGLE_DATA,
    output logic                              POR_BUSY
);
    import asp_pkg::*;

    typedef enum logic [2:0]
    {
        POR_BIST = 3'b001,
        POR_SIG  = 3'b010,
        POR_RUN  = 3'b100
    } asp_por_t;

    typedef struct packed {
        asp_por_t                por;
        logic [23:0]             por_cnt;
        logic [15:0]             ctrl;
        logic [COEF_W-1:0]       c0;
        logic [COEF_W-1:0]       c1;
        logic [COEF_W-1:0]       c2;
        logic [15:0]             rdata;
        logic [ACC_W-1:0]        acc;
        logic [7:0]              nacc;
        logic                    avg_v;
        logic [ANGLE_W-1:0]      avg;
        logic [ANGLE_W-1:0]      y1;
        logic [ANGLE_W-1:0]      y2;
        logic                    iir_v;
        logic [ANGLE_W-1:0]      iir;
        logic                    out_v;
        logic [ANGLE_W-1:0]      out;
        logic [ANGLE_W-1:0]      last;
        logic                    ov_q;
        logic [ANGLE_W-1:0]      od_q;
        logic                    busy;
    } asp_st_t;

    asp_st_t s, next_s;
    logic                   raw_v;
    logic [SAMPLE_W-1:0]    raw_d;
    logic                   buf_ready;
    logic                   buf_v;
    logic [ANGLE_W-1:0]     buf_d;
    logic [2:0]             rate;
    logic [7:0]             need;
    logic [ACC_W-1:0]       sum;
    logic signed [33:0]     fb;
    logic signed [27:0]     tc;
    logic [ANGLE_W-1:0]     comp;
    logic [ANGLE_W-1:0]     sel;
    logic                   pop;

    asp_fir u_fir
    (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (ADC_VALID && s.por == POR_RUN),
        .in_data   (ADC_DATA),
        .out_valid (raw_v),
        .out_data  (raw_d)
    );

    asp_buf2 u_buf
    (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (s.out_v),
        .in_ready  (buf_ready),
        .in_data   (s.out),
        .out_valid (buf_v),
        .out_ready (pop),
        .out_data  (buf_d)
    );

    assign rate = s.ctrl[CTRL_RATE_LSB +: RATE_W];
    assign need = 8'(1 << rate);
    // output regs are loaded when empty or being taken
    assign pop = buf_v && (!s.ov_q || ANGLE_READY);

    always_comb
    begin
        next_s = s;
        sum = '0;
        fb = '0;
        tc = '0;
        comp = '0;
        sel = '0;
        next_s.avg_v = 1'b0;
        next_s.iir_v = 1'b0;
        next_s.rdata = 16'h0000;
        // power-on self-test sequence
        unique case (s.por)
            POR_BIST:
            begin
                next_s.por_cnt = s.por_cnt + 24'h1;
                if (!s.ctrl[CTRL_STB_BIT] || s.por_cnt >= 24'(BIST_CYC - 1))
                begin
                    next_s.por = POR_SIG;
                    next_s.por_cnt = '0;
                end
            end
            POR_SIG:
            begin
                next_s.por_cnt = s.por_cnt + 24'h1;
                if (!s.ctrl[CTRL_STA_BIT] || s.por_cnt >= 24'(SIG_CYC - 1))
                begin
                    next_s.por = POR_RUN;
                    next_s.por_cnt = '0;
                end
            end
            POR_RUN:
            begin
                next_s.por_cnt = s.por_cnt;
            end
            default:
            begin
                next_s.por = POR_BIST;
            end
        endcase
        next_s.busy = (next_s.por != POR_RUN);
        // averaging: each conditioned sample is one raw angle
        sum = s.acc + {8'h00, raw_d};
        if (raw_v)
        begin
            next_s.acc = sum;
            next_s.nacc = s.nacc + 8'h1;
            if (s.nacc + 8'h1 >= need)
            begin
                next_s.avg_v = 1'b1;
                next_s.avg = 16'(sum >> rate);
                next_s.acc = '0;
                next_s.nacc = '0;
            end
        end
        // second-order recursion; bypass still takes one register cycle when disabled
        if (s.avg_v)
        begin
            fb = $signed({18'h0, s.avg}) * $signed({1'b0, s.c0})
               + $signed({18'h0, s.y1}) * $signed({1'b0, s.c1})
               - $signed({18'h0, s.y2}) * $signed({1'b0, s.c2});
            if (s.ctrl[CTRL_IIR_BIT])
            begin
                next_s.iir = 16'(fb >>> 14);
                next_s.y2 = s.y1;
                next_s.y1 = 16'(fb >>> 14);
            end
            else
            begin
                next_s.iir = s.avg;
            end
            next_s.iir_v = 1'b1;
        end
        // temperature compensation and rotation in one stage
        tc = ($signed({16'h0, TEMP_CODE}) - $signed({16'h0, TC_REF_TEMP}))
           * $signed({12'h0, TC_SLOPE});
        comp = s.ctrl[CTRL_TC_BIT] ? s.iir - 16'(tc >>> 8) : s.iir;
        sel = s.ctrl[CTRL_ROT_BIT] ? 16'h0000 - comp : comp;
        if (s.out_v && buf_ready)
            next_s.out_v = 1'b0;
        if (s.iir_v && (!s.out_v || buf_ready))
        begin
            next_s.out_v = 1'b1;
            next_s.out = sel;
        end
        // downstream output stage
        if (pop)
        begin
            next_s.ov_q = 1'b1;
            next_s.od_q = buf_d;
            next_s.last = buf_d;
        end
        else if (ANGLE_READY)
            next_s.ov_q = 1'b0;
        // registers
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                REG_IIR_C0: next_s.c0 = REG_WDATA;
                REG_IIR_C1: next_s.c1 = REG_WDATA;
                REG_IIR_C2: next_s.c2 = REG_WDATA;
                REG_CTRL:   next_s.ctrl = REG_WDATA;
                default:    next_s.ctrl = s.ctrl;
            endcase
        end
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                REG_IIR_C0: next_s.rdata = s.c0;
                REG_IIR_C1: next_s.rdata = s.c1;
                REG_IIR_C2: next_s.rdata = s.c2;
                REG_CTRL:   next_s.rdata = s.ctrl;
                REG_TEMP:   next_s.rdata = {4'h0, TEMP_CODE};
                REG_STATUS: next_s.rdata = s.busy ? ST_BIT_POR : 16'h0000;
                REG_ANGLE:  next_s.rdata = s.last;
                default:    next_s.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s <= '0;
            s.por <= POR_BIST;
            s.busy <= 1'b1;
            s.ctrl <= CTRL_RESET;
            s.c0 <= COEF_RESET;
            s.c1 <= COEF_RESET;
            s.c2 <= COEF_RESET;
        end
        else if (CE)
            s <= next_s;
    end

    assign REG_RDATA = s.rdata;
    assign ANGLE_VALID = s.ov_q;
    assign ANGLE_DATA = s.od_q;
    assign POR_BUSY = s.busy;

    avg_count_a : assert property (@(posedge CLK) disable iff (!RST_N)
        s.nacc < need || rate != s.ctrl[2:0]) else $error("average overran count");
    avg_emit_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && raw_v && s.nacc + 8'h1 >= need |=> s.avg_v && s.acc == '0)
        else $error("average not emitted");
    avg_value_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && raw_v && rate == 3'h0 && s.nacc == 8'h0 |=> s.avg == $past(raw_d))
        else $error("single sample average wrong");
    iir_bypass_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && s.avg_v && !s.ctrl[CTRL_IIR_BIT] |=> s.iir == $past(s.avg))
        else $error("iir not bypassed");
    iir_state_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && s.avg_v && !s.ctrl[CTRL_IIR_BIT] |=> $stable(s.y1))
        else $error("iir state moved while off");
    coef_write_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && REG_WR && REG_ADDR == REG_IIR_C0 |=> s.c0 == $past(REG_WDATA))
        else $error("coefficient not stored");
    rot_apply_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && s.iir_v && !s.out_v && s.ctrl[CTRL_ROT_BIT] && !s.ctrl[CTRL_TC_BIT]
        |=> s.out == 16'h0000 - $past(s.iir)) else $error("rotation not applied");
    tc_off_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && s.iir_v && !s.out_v && !s.ctrl[CTRL_ROT_BIT] && !s.ctrl[CTRL_TC_BIT]
        |=> s.out == $past(s.iir)) else $error("compensation not skipped");
    por_skip_a : assert property (@(posedge CLK) disable iff (!RST_N)
        CE && s.por == POR_SIG && !s.ctrl[CTRL_STA_BIT] |=> s.por == POR_RUN)
        else $error("unselected test ran");
endmodule

//--- bench/asp_adc_model.sv
// Purpose: stand-in for the adc sample stream that feeds the chain
// Assumes: four equal samples per decimation group, one sample every 12 clocks
// Notes:   group level falls by step_a and step_b in turn; junk between samples
`timescale 1ns/1ps
module asp_adc_model
(
    // clock
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        run,
    input  wire logic [15:0] step_a,
    input  wire logic [15:0] step_b,
    // stream
    output logic             valid = 1'b0,
    output logic [15:0]      data = 16'h5A5A,
    output logic [31:0]      n_sent = 32'h0
);
    logic [15:0] level;
    logic [3:0]  cnt;
    logic [1:0]  slot;
    logic        alt;

    // the line is never left holding the last sample, so stale reads show up
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n || !run)
        begin
            valid <= 1'b0;
            data  <= ~data;
            level <= 16'hF000;
            cnt   <= 4'h0;
            slot  <= 2'h0;
            alt   <= 1'b0;
        end
        else if (cnt != 4'h0)
        begin
            valid <= 1'b0;
            data  <= ~data;
            cnt   <= cnt - 4'h1;
        end
        else
        begin
            valid  <= 1'b1;
            data   <= level;
            n_sent <= n_sent + 32'h1;
            cnt    <= 4'hB;
            slot   <= slot + 2'h1;
            if (slot == 2'h3)
            begin
                level <= level - (alt ? step_b : step_a);
                alt   <= !alt;
            end
        end
    end
endmodule

//--- bench/asp_chain_test.sv
// Purpose: self-checking bench for the angle sample preprocessing chain
// Assumes: raw angle settles to 0x8000 minus the group step of the adc model
// Notes:   short self-test counts keep power-on brief
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module asp_chain_test;
    import asp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        run = 1'b0;
    logic [15:0] step_a = 16'h0100;
    logic [15:0] step_b = 16'h0300;
    logic        adc_valid;
    logic [15:0] adc_data;
    logic [31:0] n_sent;
    logic [11:0] temp = 12'h800;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ready = 1'b1;
    logic [15:0] rdata;
    logic [15:0] ang;
    logic        ang_valid;
    logic        busy;
    int          n_fail = 0;
    int          tests_run = 0;

    always #2.5 clk = ~clk;

    asp_adc_model adc (.clk(clk), .rst_n(rst_n), .run(run), .step_a(step_a),
        .step_b(step_b), .valid(adc_valid), .data(adc_data), .n_sent(n_sent));

    asp_chain #(.BIST_CYC(8), .SIG_CYC(16)) dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
        .ADC_VALID(adc_valid), .ADC_DATA(adc_data), .TEMP_CODE(temp), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .ANGLE_VALID(ang_valid), .ANGLE_READY(ready), .ANGLE_DATA(ang), .POR_BUSY(busy));

    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task do_reset;
        @(posedge clk);
        run   <= 1'b0;
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
    endtask

    // host keeps off the register port until power-on is over
    task wait_por;
        int i;
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        if (busy !== 1'b0)
        begin
            n_fail++;
            give_verdict;
        end
    endtask

    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task boot(input logic [15:0] ctrl);
        do_reset;
        wait_por;
        reg_wr(REG_CTRL, ctrl);
    endtask

    task get_word(output logic [15:0] d);
        int i;
        // look just after the edge: the word shown now is taken at the next edge
        #1;
        for (i = 0; i < 20000 && !(ang_valid === 1'b1 && ready === 1'b1); i++)
        begin
            @(posedge clk);
            #1;
        end
        if (i == 20000)
        begin
            n_fail++;
            give_verdict;
        end
        d = ang;
        @(posedge clk);
    endtask

    task skip(input int k);
        logic [15:0] d;
        repeat (k) get_word(d);
    endtask

    task t_por;
        logic [15:0] d;
        // selection must land on the first edge after release
        @(posedge clk);
        run   <= 1'b0;
        rst_n <= 1'b0;
        tick(4);
        addr  <= REG_CTRL;
        wdata <= 16'h00C0;
        wr    <= 1'b1;
        rst_n <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        tick(3);
        #1 `CHK("busy with self-test", 1'b1, busy);
        wait_por;
        reg_rd(REG_STATUS, d);
        `CHK("status after power-on", 16'h0000, d);
        do_reset;
        tick(3);
        #1 `CHK("busy without self-test", 1'b0, busy);
    endtask

    task t_regs;
        logic [15:0] d;
        boot(16'h00A5);
        reg_rd(REG_CTRL, d);
        `CHK("ctrl readback", 16'h00A5, d);
        @(posedge clk);
        #1 `CHK("read data idle", 16'h0000, rdata);
        reg_wr(REG_IIR_C1, 16'h1234);
        reg_rd(REG_IIR_C1, d);
        `CHK("coefficient readback", 16'h1234, d);
        @(posedge clk);
        temp <= 12'h9AB;
        reg_wr(REG_TEMP, 16'hFFFF);
        reg_rd(REG_TEMP, d);
        `CHK("temperature read only", 16'h09AB, d);
        reg_rd(4'hF, d);
        `CHK("unmapped read", 16'h0000, d);
        @(posedge clk);
        temp <= 12'h800;
    endtask

    // alternating steps make raw angles 0x7F00 and 0x7D00 in turn
    task t_rates;
        int          n;
        logic [15:0] d;
        logic [31:0] s0;
        for (n = 0; n < 8; n++)
        begin
            boot(16'(n));
            run <= 1'b1;
            skip(1);
            get_word(d);
            s0 = n_sent;
            get_word(d);
            `CHK("samples per result", 32'(4 << n), n_sent - s0);
            if (n > 0) `CHK("averaged angle", 16'h7E00, d);
        end
    endtask

    task t_stages;
        logic [15:0] d;
        logic [15:0] r;
        step_b <= 16'h0100;
        boot(16'h0000);
        reg_wr(REG_IIR_C0, 16'h2000);
        reg_wr(REG_CTRL, 16'h0008);
        run <= 1'b1;
        skip(2);
        get_word(d);
        `CHK("filtered angle", 16'h3F80, d);
        reg_wr(REG_CTRL, 16'h0000);
        skip(2);
        get_word(d);
        `CHK("bypassed angle", 16'h7F00, d);
        @(posedge clk);
        temp <= 12'h900;
        reg_wr(REG_CTRL, 16'h0020);
        skip(2);
        get_word(d);
        `CHK("compensated angle", 16'h7EF0, d);
        reg_rd(REG_ANGLE, r);
        `CHK("last angle register", 16'h7EF0, r);
        // direction chosen so that the angle rises with the target
        reg_wr(REG_CTRL, 16'h0010);
        skip(2);
        get_word(d);
        `CHK("reversed angle", 16'h8100, d);
    endtask

    task t_stall;
        logic [15:0] held;
        logic [15:0] a;
        logic [15:0] b;
        step_b <= 16'h0300;
        reg_wr(REG_CTRL, 16'h0000);
        skip(2);
        @(posedge clk);
        ready <= 1'b0;
        tick(60);
        #1 held = ang;
        `CHK("valid under stall", 1'b1, ang_valid);
        tick(250);
        #1 `CHK("word held under stall", held, ang);
        @(posedge clk);
        ready <= 1'b1;
        get_word(a);
        get_word(b);
        `CHK("first drained word", held, a);
        `CHK("second drained word differs", 1'b1, a !== b);
    endtask

    initial
    begin
        t_por;
        t_regs;
        t_rates;
        t_stages;
        t_stall;
        give_verdict;
    end
endmodule
